// ### hdl/edge_timestamp_capture.sv
// Four-channel edge timestamp capture with a 5 or 15 slot input image.
// Assumes pins arrive asynchronously and the partner reads bytes by address.
//
// Functional notes
// RL1 - Each qualifying edge records timer value, input state and sequence number.
// RL2 - Configuration selects rising and/or falling edges as capture triggers.
// RL3 - Four digital inputs, each monitored and reflected in the state byte.
// RL4 - Small variant: twenty byte image holding five entries.
// RL5 - Large variant: sixty byte image holding fifteen entries.
// RL6 - Successive entries go to consecutive slots in order of occurrence.
// RL7 - Each entry is four bytes; slot k starts at byte 4k.
// RL8 - Byte 0: input states after the edge, bits 7..4 read zero.
// RL9 - Byte 1: sequence number 0..127, starting at 1, chronological.
// RL10 - Bytes 2 and 3: low sixteen bits of the microsecond counter.
// RL11 - Microsecond counter starts at zero at power-on and wraps to zero.
// RL12 - No output image bytes; data flows only toward the controller.
// RL13 - Fieldbus master selects an entry by subindex under its object index.
// RL14 - Slot-based fieldbus master reaches fields at 6000h plus slot number.
// RL15 - Module fault indicator flashes while the configuration is erroneous.
// RL16 - Write position wraps after the last slot; sequence rolls 127 to 0.
`include "edge_cap_cfg.svh"

module edge_timestamp_capture
#(
	parameter int NUM_INPUTS        = `ETS_NUM_INPUTS,
	parameter int MAX_SLOTS         = `ETS_SLOTS_LARGE,
	parameter int FLASH_HALF_CYCLES = `ETS_FLASH_HALF_CYC
) (
	input  wire logic                     CLK,
	input  wire logic                     RESET_N,
	input  wire logic [NUM_INPUTS-1:0]    DIGITAL_INPUT_CHANNEL,
	input  wire edge_cap_pkg::variant_code_t CFG_VARIANT,
	input  wire edge_cap_pkg::edge_sel_t  CFG_EDGE_SEL,
	input  wire logic                     IMG_RD_EN,
	input  wire edge_cap_pkg::img_addr_t  IMG_ADDR,
	output logic [7:0]                    IMG_RD_DATA,
	output logic                          IMG_RD_VALID,
	output logic [6:0]                    IMG_SIZE,
	output logic [NUM_INPUTS-1:0]         CHANNEL_LED,
	output logic                          MODULE_FAULT_INDICATOR
);

	import edge_cap_pkg::*;

	// ****************************************************************
	// Parameter checks
	// ****************************************************************
	generate
		if (NUM_INPUTS < 1 || NUM_INPUTS > 8)
		begin : g_bad_inputs
			$error("edge_timestamp_capture: NUM_INPUTS must be 1..8");
		end
		if (MAX_SLOTS != `ETS_SLOTS_LARGE)
		begin : g_bad_slots
			$error("edge_timestamp_capture: MAX_SLOTS must cover the large variant");
		end
		if (FLASH_HALF_CYCLES < 1 || FLASH_HALF_CYCLES > 16777215)
		begin : g_bad_flash
			$error("edge_timestamp_capture: FLASH_HALF_CYCLES out of range");
		end
	endgenerate

	// ****************************************************************
	// Decoding helpers
	// ****************************************************************
	function automatic logic variant_legal(input variant_code_t v);
		variant_legal = (v == `ETS_VARIANT_SMALL) || (v == `ETS_VARIANT_LARGE);
	endfunction : variant_legal

	function automatic slot_idx_t slot_last(input variant_code_t v);
		if (v == `ETS_VARIANT_LARGE)
			slot_last = 4'(`ETS_SLOTS_LARGE - 1); // RL5
		else
			slot_last = 4'(`ETS_SLOTS_SMALL - 1); // RL4
	endfunction : slot_last

	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic [NUM_INPUTS-1:0] sync1_r;
	logic [NUM_INPUTS-1:0] sync2_r;
	logic [NUM_INPUTS-1:0] sync3_r;
	logic [NUM_INPUTS-1:0] stable_r;
	logic [NUM_INPUTS-1:0] stable_nxt;
	logic [NUM_INPUTS-1:0] rise;
	logic [NUM_INPUTS-1:0] fall;
	variant_code_t         variant_r;
	edge_sel_t             edge_sel_r;
	logic                  cfg_ok;
	logic                  capture;
	slot_idx_t             ptr_r;
	slot_idx_t             ptr_nxt;
	logic [7:0]            seq_r;
	logic [7:0]            seq_nxt;
	entry_t                new_entry;
	entry_t                entry_r [MAX_SLOTS];
	logic                  us_tick;
	logic [`ETS_TIMER_WIDTH-1:0] us_count;
	slot_idx_t             rd_slot;
	logic                  rd_in_range;
	logic [7:0]            rd_byte;
	logic [23:0]           flash_cnt_r;

	// ****************************************************************
	// Microsecond time base
	// ****************************************************************
	microsecond_timer #(
		.TICK_CYCLES (`ETS_TICK_CYCLES),
		.WIDTH       (`ETS_TIMER_WIDTH)
	) u_timer (
		.clk      (CLK),
		.reset_n  (RESET_N),
		.us_tick  (us_tick),
		.us_count (us_count)
	);

	// ****************************************************************
	// Input synchroniser and edge detection
	// ****************************************************************
	always_ff @(posedge CLK)
	begin
		if (!RESET_N)
		begin
			sync1_r <= '0;
			sync2_r <= '0;
			sync3_r <= '0;
		end
		else
		begin
			sync1_r <= DIGITAL_INPUT_CHANNEL;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
		end
	end

	// A channel changes only once stages two and three agree
	always_comb
	begin
		stable_nxt = stable_r;
		for (int i = 0; i < NUM_INPUTS; i++)
		begin
			if (sync2_r[i] == sync3_r[i])
				stable_nxt[i] = sync3_r[i]; // RL3
		end
	end

	assign rise = ~stable_r & stable_nxt;
	assign fall = stable_r & ~stable_nxt;

	always_ff @(posedge CLK)
	begin
		if (!RESET_N)
			stable_r <= '0;
		else
			stable_r <= stable_nxt;
	end

	assign CHANNEL_LED = stable_r; // RL3

	// ****************************************************************
	// Configuration
	// ****************************************************************
	always_ff @(posedge CLK)
	begin
		if (!RESET_N)
		begin
			variant_r  <= `ETS_VARIANT_SMALL;
			edge_sel_r <= 2'h0;
		end
		else
		begin
			variant_r  <= CFG_VARIANT;
			edge_sel_r <= CFG_EDGE_SEL;
		end
	end

	assign cfg_ok  = variant_legal(variant_r);
	assign capture = cfg_ok &&
		(|((rise & {NUM_INPUTS{edge_sel_r[`ETS_EDGE_RISING_BIT]}}) |
		   (fall & {NUM_INPUTS{edge_sel_r[`ETS_EDGE_FALL_BIT]}}))); // RL2

	always_ff @(posedge CLK)
	begin
		if (!RESET_N)
			IMG_SIZE <= `ETS_IMG_BYTES_SMALL;
		else if (variant_r == `ETS_VARIANT_LARGE)
			IMG_SIZE <= `ETS_IMG_BYTES_LARGE; // RL5
		else
			IMG_SIZE <= `ETS_IMG_BYTES_SMALL; // RL4
	end

	// ****************************************************************
	// Entry formation, write position and sequence number
	// ****************************************************************
	always_comb
	begin
		new_entry.state = 8'(stable_nxt); // RL8
		new_entry.seq   = seq_r; // RL9
		new_entry.ts    = us_count[15:0]; // RL10
	end

	assign ptr_nxt = (ptr_r >= slot_last(variant_r)) ? 4'h0 : ptr_r + 4'h1; // RL16
	assign seq_nxt = (seq_r == `ETS_SEQ_MAX) ? `ETS_SEQ_WRAP : seq_r + 8'h01; // RL16

	// A change of variant restarts the image from slot 0 and number 1
	always_ff @(posedge CLK)
	begin
		if (!RESET_N || (variant_r != CFG_VARIANT))
		begin
			ptr_r <= 4'h0;
			seq_r <= `ETS_SEQ_START;
		end
		else if (capture)
		begin
			ptr_r <= ptr_nxt; // RL6
			seq_r <= seq_nxt; // RL9
		end
	end

	genvar g;
	generate
		for (g = 0; g < MAX_SLOTS; g++)
		begin : g_slot
			always_ff @(posedge CLK)
			begin
				if (!RESET_N)
					entry_r[g] <= '0;
				else if (capture && (ptr_r == 4'(g)))
					entry_r[g] <= new_entry; // RL1
			end
		end
	endgenerate

	// ****************************************************************
	// Input image read port (no output image exists)
	// ****************************************************************
	assign rd_slot     = IMG_ADDR[5:2]; // RL7
	assign rd_in_range = (rd_slot <= slot_last(variant_r));

	always_comb
	begin
		rd_byte = 8'h00;
		if (rd_in_range)
		begin
			case (IMG_ADDR[1:0])
				`ETS_OFS_STATE: rd_byte = entry_r[rd_slot].state;
				`ETS_OFS_SEQ:   rd_byte = entry_r[rd_slot].seq;
				`ETS_OFS_TS_LO: rd_byte = entry_r[rd_slot].ts[7:0];
				`ETS_OFS_TS_HI: rd_byte = entry_r[rd_slot].ts[15:8];
				default:        rd_byte = 8'h00;
			endcase
		end
	end

	always_ff @(posedge CLK)
	begin
		if (!RESET_N)
		begin
			IMG_RD_DATA  <= 8'h00;
			IMG_RD_VALID <= 1'b0;
		end
		else
		begin
			IMG_RD_VALID <= IMG_RD_EN; // RL12
			if (IMG_RD_EN)
				IMG_RD_DATA <= rd_byte; // RL7
		end
	end

	// ****************************************************************
	// Module fault indicator
	// ****************************************************************
	always_ff @(posedge CLK)
	begin
		if (!RESET_N || cfg_ok)
		begin
			flash_cnt_r            <= 24'h000000;
			MODULE_FAULT_INDICATOR <= 1'b0;
		end
		else if (flash_cnt_r == 24'(FLASH_HALF_CYCLES - 1))
		begin
			flash_cnt_r            <= 24'h000000;
			MODULE_FAULT_INDICATOR <= ~MODULE_FAULT_INDICATOR; // RL15
		end
		else
			flash_cnt_r <= flash_cnt_r + 24'h000001;
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESET_N);

	sequence s_capture;
		capture && (variant_r == CFG_VARIANT);
	endsequence

	sequence s_rise_edge;
		cfg_ok && (|rise) && edge_sel_r[`ETS_EDGE_RISING_BIT];
	endsequence
	a_entry_content: assert property (s_capture |=> // RL1
		entry_r[$past(ptr_r)] == {$past(us_count[15:0]), $past(seq_r), 8'(stable_r)})
		else $error("captured entry does not match its sources");
	a_rise_trigger: assert property (s_rise_edge |-> capture) // RL2
		else $error("enabled rising edge did not trigger a capture");
	a_no_edge_idle: assert property ((edge_sel_r == 2'h0) |-> !capture) // RL2
		else $error("capture with no edge selected");
	a_slot_step: assert property ((s_capture ##0 (ptr_r < slot_last(variant_r))) // RL6
		|=> ptr_r == $past(ptr_r) + 4'h1)
		else $error("write position did not advance by one slot");
	a_slot_wrap: assert property ((s_capture ##0 (ptr_r == slot_last(variant_r))) // RL16
		|=> ptr_r == 4'h0)
		else $error("write position did not wrap after last slot");
	a_seq_roll: assert property ((s_capture ##0 (seq_r == `ETS_SEQ_MAX)) |=> // RL16
		seq_r == `ETS_SEQ_WRAP)
		else $error("sequence number did not roll to zero");
	a_seq_count: assert property ((s_capture ##0 (seq_r != `ETS_SEQ_MAX)) |=> // RL9
		seq_r == $past(seq_r) + 8'h01)
		else $error("sequence number did not advance");
	a_state_upper_zero: assert property ((IMG_RD_EN && (IMG_ADDR[1:0] == `ETS_OFS_STATE)) // RL8
		|=> IMG_RD_VALID && (IMG_RD_DATA[7:NUM_INPUTS] == '0))
		else $error("state byte upper bits not zero");
	a_read_range: assert property ((IMG_RD_EN && !rd_in_range) |=> // RL4
		IMG_RD_VALID && (IMG_RD_DATA == 8'h00))
		else $error("read beyond variant image not zero");
	a_fault_quiet: assert property (cfg_ok [*2] |-> !MODULE_FAULT_INDICATOR) // RL15
		else $error("fault indicator lit with good configuration");
	a_fault_toggle: assert property ((!cfg_ok && // RL15
		(flash_cnt_r == 24'(FLASH_HALF_CYCLES - 1))) |=>
		MODULE_FAULT_INDICATOR != $past(MODULE_FAULT_INDICATOR))
		else $error("fault indicator did not toggle");
	a_timer_wrap: assert property ((us_tick && (&us_count)) |=> us_count == '0) // RL11
		else $error("microsecond counter did not wrap to zero");
	a_timer_step: assert property (us_tick |=> us_count == $past(us_count) + 1'b1) // RL11
		else $error("microsecond counter did not advance by one");

endmodule : edge_timestamp_capture

// ### common/edge_cap_cfg.svh
// Constants of the edge timestamp capture block: offsets, field positions,
// reset values and timing counts. Included by the package, the capture block and the testbench.
`ifndef EDGE_CAP_CFG_SVH
`define EDGE_CAP_CFG_SVH

// ****************************************************************
// Clock and time base
// ****************************************************************
`define ETS_CLK_HZ          40000000
`define TIMESTAMP_LOW_WORD_PER_S        1000000
`define ETS_TICK_CYCLES     (`ETS_CLK_HZ / `TIMESTAMP_LOW_WORD_PER_S)
`define ETS_TIMER_WIDTH     32
`define ETS_FLASH_HZ        2
`define ETS_FLASH_HALF_CYC  (`ETS_CLK_HZ / (2 * `ETS_FLASH_HZ))

// ****************************************************************
// Entry layout in the input image
// ****************************************************************
`define ETS_ENTRY_BYTES     4
`define ETS_OFS_STATE       2'h0
`define ETS_OFS_SEQ         2'h1
`define ETS_OFS_TS_LO       2'h2
`define ETS_OFS_TS_HI       2'h3
`define ETS_NUM_INPUTS      4
`define ETS_SLOTS_SMALL     5
`define ETS_SLOTS_LARGE     15
`define ETS_IMG_BYTES_SMALL 7'h14
`define ETS_IMG_BYTES_LARGE 7'h3C

// ****************************************************************
// Reset values and configuration codes
// ****************************************************************
`define ETS_SEQ_START       8'h01
`define ETS_SEQ_MAX         8'h7F
`define ETS_SEQ_WRAP        8'h00
`define ETS_VARIANT_SMALL   2'h0
`define ETS_VARIANT_LARGE   2'h1
`define ETS_EDGE_RISING_BIT 0
`define ETS_EDGE_FALL_BIT   1

`endif

// ### common/edge_cap_pkg.sv
// Types shared by the edge timestamp capture block.
// Assumes edge_cap_cfg.svh is on the include path.
`include "edge_cap_cfg.svh"

package edge_cap_pkg;

	typedef logic [1:0] variant_code_t;
	typedef logic [1:0] edge_sel_t;
	typedef logic [3:0] slot_idx_t;
	typedef logic [5:0] img_addr_t;

	typedef struct packed {
		logic [15:0] ts;
		logic [7:0]  seq;
		logic [7:0]  state;
	} entry_t;

endpackage : edge_cap_pkg

// ### hdl/microsecond_timer.sv
// Free-running microsecond counter with its prescaler.
// Assumes a single clock with synchronous active-low reset at power-on.
module microsecond_timer #(
	parameter int TICK_CYCLES = 40,
	parameter int WIDTH       = 32
) (
	input  wire logic             clk,
	input  wire logic             reset_n,
	output logic                  us_tick,
	output logic [WIDTH-1:0]      us_count
);

	localparam int PW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

	logic [PW-1:0] pre_r;

	generate
		if (TICK_CYCLES < 1 || WIDTH < 16)
		begin : g_bad
			$error("microsecond_timer: TICK_CYCLES >= 1 and WIDTH >= 16 required");
		end
	endgenerate

	assign us_tick = (pre_r == PW'(TICK_CYCLES - 1));

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			pre_r <= '0;
		else if (us_tick)
			pre_r <= '0;
		else
			pre_r <= pre_r + 1'b1;
	end

	// Starts at zero from power-on and wraps to zero past its maximum
	always_ff @(posedge clk)
	begin
		if (!reset_n)
			us_count <= '0;
		else if (us_tick)
			us_count <= us_count + 1'b1; // RL11
	end

endmodule : microsecond_timer

// ### tb/image_reader.sv
// Backplane reader model: fetches bytes and whole entries of the input image.
// Assumes the capture block answers one clock after each read strobe.
module image_reader
	import edge_cap_pkg::*;
(
	input  wire logic                    CLK,
	output logic                         RD_EN,
	output edge_cap_pkg::img_addr_t      ADDR,
	input  wire logic [7:0]              RD_DATA,
	input  wire logic                    RD_VALID
);
	timeunit 1ns;
	timeprecision 1ps;

	initial
	begin
		RD_EN = 1'b0;
		ADDR  = 6'h00;
	end

	// ****************************************************************
	// Access tasks
	// ****************************************************************
	// Address is scrambled once the strobe drops so stale values never help
	task automatic read_byte(input img_addr_t a, output logic [7:0] d, output logic ok);
		@(negedge CLK);
		RD_EN = 1'b1;
		ADDR  = a;
		@(negedge CLK);
		ok    = RD_VALID;
		d     = RD_DATA;
		RD_EN = 1'b0;
		ADDR  = ~a;
	endtask : read_byte

	task automatic read_entry(input int slot, output entry_t e, output logic ok);
		logic [7:0] d;
		logic       v;
		ok = 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			read_byte(img_addr_t'(4 * slot + i), d, v);
			ok    = ok & v;
			e[8*i +: 8] = d;
		end
	endtask : read_entry
endmodule : image_reader

// ### tb/tb.sv
// Testbench of the edge timestamp capture block.
// Assumes edge_cap_cfg.svh on the include path and a 40 MHz clock.
`include "edge_cap_cfg.svh"

`define CHK(name, exp, got) \
	begin \
		checked++; \
		if ((got) !== (exp)) \
		begin \
			n_errors++; \
			$display("wrong value %s expected %0h seen %0h", name, exp, got); \
		end \
	end

module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import edge_cap_pkg::*;

	localparam int LIMIT = 20000;

	logic          clk      = 1'b0;
	logic          reset_n  = 1'b0;
	logic [3:0]    pins     = 4'h0;
	variant_code_t variant  = 2'h0;
	edge_sel_t     edge_sel = 2'h1;
	logic          rd_en;
	img_addr_t     addr;
	logic [7:0]    rd_data;
	logic          rd_valid;
	logic [6:0]    img_size;
	logic [3:0]    led;
	logic          fault;
	int            n_errors = 0;
	int            checked  = 0;
	int            cyc      = 0;
	int            exp_slot = 0;
	int            exp_seq  = 1;
	int            slots    = 5;

	always #12.5 clk = ~clk;

	edge_timestamp_capture #(.FLASH_HALF_CYCLES(4)) dut (
		.CLK                    (clk),
		.RESET_N                (reset_n),
		.DIGITAL_INPUT_CHANNEL  (pins),
		.CFG_VARIANT            (variant),
		.CFG_EDGE_SEL           (edge_sel),
		.IMG_RD_EN              (rd_en),
		.IMG_ADDR               (addr),
		.IMG_RD_DATA            (rd_data),
		.IMG_RD_VALID           (rd_valid),
		.IMG_SIZE               (img_size),
		.CHANNEL_LED            (led),
		.MODULE_FAULT_INDICATOR (fault)
	);

	image_reader reader (
		.CLK      (clk),
		.RD_EN    (rd_en),
		.ADDR     (addr),
		.RD_DATA  (rd_data),
		.RD_VALID (rd_valid)
	);

	// ****************************************************************
	// Helpers
	// ****************************************************************
	task automatic finish_test();
		if (n_errors == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : finish_test

	always @(posedge clk)
	begin
		if (reset_n)
			cyc++;
		if (cyc == LIMIT)
		begin
			n_errors++;
			finish_test();
		end
	end

	// Drive the pins, then check the entry the edge should have left
	task automatic apply(input logic [3:0] v);
		entry_t      e;
		logic        ok;
		logic        hit;
		logic [15:0] us16;
		hit = (edge_sel[0] & |(v & ~pins)) | (edge_sel[1] & |(~v & pins));
		hit = hit & (variant < 2'h2);
		@(negedge clk);
		pins = v;
		us16 = 16'((cyc + 3) / 40);
		repeat (6) @(negedge clk);
		`CHK("leds", v, led)
		if (hit)
		begin
			reader.read_entry(exp_slot, e, ok);
			`CHK("valid", 1'b1, ok)
			`CHK("state", {4'h0, v}, e.state)
			`CHK("seq", exp_seq[7:0], e.seq)
			`CHK("ts", us16, e.ts)
			exp_slot = (exp_slot + 1) % slots;
			exp_seq  = (exp_seq + 1) % 128;
		end
	endtask : apply

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial
	begin
		logic [7:0] d;
		logic       ok;
		int         ones;
		repeat (6) @(negedge clk);
		reset_n = 1'b1;
		@(negedge clk);
		`CHK("size", 7'h14, img_size)
		`CHK("fault", 1'b0, fault)
		for (int m = 1; m < 4; m++)
		begin
			edge_sel = edge_sel_t'(m);
			for (int i = 0; i < 4; i++)
				apply(i[0] ? 4'h0 : (i[1] ? 4'h6 : 4'h9));
		end
		apply(4'hF);
		reader.read_byte(6'h14, d, ok);
		`CHK("past small", 8'h00, d)
		variant  = 2'h1;
		exp_slot = 0;
		exp_seq  = 1;
		slots    = 15;
		repeat (4) @(negedge clk);
		`CHK("size", 7'h3C, img_size)
		for (int i = 0; i < 140; i++)
			apply(i[0] ? 4'h0 : 4'hF);
		reader.read_byte(6'h3C, d, ok);
		`CHK("past large", 8'h00, d)
		variant = 2'h2;
		ones    = 0;
		for (int i = 0; i < 20; i++)
		begin
			@(negedge clk);
			if (fault === 1'b1)
				ones++;
		end
		`CHK("flash", 1'b1, ones >= 8 && ones <= 12)
		apply(4'h5);
		reader.read_byte(6'h01, d, ok);
		`CHK("no capture", 8'h08, d)
		variant  = 2'h0;
		exp_slot = 0;
		exp_seq  = 1;
		slots    = 5;
		repeat (4) @(negedge clk);
		`CHK("fault", 1'b0, fault)
		apply(4'h0);
		edge_sel = 2'h0;
		apply(4'hA);
		reader.read_byte(6'h05, d, ok);
		`CHK("no edge", 8'h09, d)
		finish_test();
	end
endmodule : tb
